//--- oos_pkg.sv
// Purpose: shared constants, types and decode helpers for the oversampled output sequencer
// Assumes: 100 MHz clock, two channels sharing one oversampling factor
// Notes: factor table lists the factors that give a whole-microsecond sample period for a 1 ms cycle
package oos_pkg;
  localparam int CH_N = 2;
  localparam int MAX_FACTOR = 1000;
  localparam int SEQ_W = 8;
  localparam int IDX_W = 10;
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int TIME_W = 32;
  localparam int SEQ_LSB = CH_N * MAX_FACTOR;
  localparam int CHK_BIT = SEQ_LSB + SEQ_W;
  localparam int BLK_W = CHK_BIT + 1;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int CYCLE_TIME_MS = 1;
  localparam int WDOG_TIME_MS = 100;
  localparam logic [ADDR_W-1:0] ADDR_SEQ_ERR = 12'h30d;
  localparam logic [ADDR_W-1:0] ADDR_POL_CH1 = 12'hf00;
  localparam logic [ADDR_W-1:0] ADDR_POL_CH2 = 12'hf01;
  localparam logic [ADDR_W-1:0] ADDR_NEXT_LANE = 12'h001;
  localparam logic [BYTE_W-1:0] SEQ_ERR_RESET = 8'h00;
  localparam logic [BYTE_W-1:0] POL_RESET = 8'h00;
  localparam int POL_EN_BIT = 0;
  localparam int POL_CC_LSB = 1;
  localparam int POL_WD_LSB = 4;
  localparam int ACT_W = 3;
  localparam logic [IDX_W-1:0] FACTOR_ONE = 10'h001;

  typedef enum logic [2:0] {
    ACT_ZERO = 3'b000,
    ACT_ONE = 3'b001,
    ACT_HOLD = 3'b010,
    ACT_KEEP_BUFFER = 3'b011,
    ACT_TOGGLE_OUTPUT = 3'b100,
    ACT_FLOAT = 3'b101
  } oos_action_t;

  // on watchdog expiry the same code replays the block of the last cycle
  localparam oos_action_t ACT_RESEND_LAST_CYCLE = ACT_KEEP_BUFFER;

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_CYCLE_ERR = 2'b01,
    MODE_WATCHDOG = 2'b10
  } oos_mode_t;

  // implausible factors fall back to one sample per cycle
  function automatic logic [IDX_W-1:0] oos_eff_factor(input logic [IDX_W-1:0] f);
    case (f)
      10'h001, 10'h002, 10'h004, 10'h005, 10'h008, 10'h00a, 10'h014, 10'h019,
      10'h028, 10'h032, 10'h064, 10'h07d, 10'h0c8, 10'h0fa, 10'h1f4, 10'h3e8: return f;
      default: return FACTOR_ONE;
    endcase
  endfunction
endpackage

//--- oos_stream_if.sv
// Purpose: valid/ready word carrier between the sequencer's own modules
// Assumes: one clock domain
// Notes: src drives data and valid, snk drives ready
`timescale 1ns/10ps
interface oos_stream_if #(parameter int W = 8);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src(output data, output valid, input ready);
  modport snk(input data, input valid, output ready);
endinterface

//--- oos_fifo.sv
// Purpose: block FIFO between the fieldbus side and the cycle-rate take-over
// Assumes: reader pops at most once per cycle sync, so it really fills
// Notes: ready and valid come from flip-flops
`timescale 1ns/10ps
module oos_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill and drain sides
  oos_stream_if.snk wr,
  oos_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;
  logic not_full;
  logic not_empty;

  assign push = wr.valid & not_full;
  assign pop = rd.ready & not_empty;
  assign wr.ready = not_full;
  assign rd.valid = not_empty;
  assign rd.data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      not_full <= 1'b0;
      not_empty <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      count <= next_count;
      not_full <= (next_count != FULL_CNT);
      not_empty <= (next_count != '0);
    end
  end

  fifo_flags_a: assert property (@(posedge clk) disable iff (!rst_b)
    (count == FULL_CNT) |-> !wr.ready && rd.valid)
    else $error("fifo flags disagree with fill level");
endmodule

//--- oos_sync_gen.sv
// Purpose: cycle-rate and sample-rate sync pulses from the local clock
// Assumes: factor only changes effect at a cycle sync
// Notes: sample spacing by accumulation, no divider needed
`timescale 1ns/10ps
module oos_sync_gen
  import oos_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic [IDX_W-1:0] factor,
  // sync pulses and position
  output logic cyc_sync,
  output logic smp_sync,
  output logic [IDX_W-1:0] smp_idx,
  output logic [IDX_W-1:0] eff_factor
);
  localparam logic [TIME_W-1:0] CYC_LEN = TIME_W'(CYCLE_CLKS);
  localparam logic [TIME_W-1:0] CYC_LAST = TIME_W'(CYCLE_CLKS - 1);
  logic [TIME_W-1:0] cyc_cnt;
  logic [TIME_W-1:0] acc;
  logic [TIME_W-1:0] acc_sum;

  assign acc_sum = acc + TIME_W'(eff_factor);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cyc_cnt <= CYC_LAST;
      cyc_sync <= 1'b0;
      eff_factor <= FACTOR_ONE;
    end else if (cyc_cnt == CYC_LAST) begin
      cyc_cnt <= '0;
      cyc_sync <= 1'b1;
      eff_factor <= oos_eff_factor(factor);
    end else begin
      cyc_cnt <= cyc_cnt + 1'b1;
      cyc_sync <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc <= '0;
      smp_sync <= 1'b0;
      smp_idx <= '0;
    end else if (cyc_cnt == CYC_LAST) begin
      acc <= '0;
      smp_sync <= 1'b1;
      smp_idx <= '0;
    end else if (acc_sum >= CYC_LEN) begin
      acc <= acc_sum - CYC_LEN;
      smp_sync <= 1'b1;
      smp_idx <= IDX_W'(smp_idx + 1'b1);
    end else begin
      acc <= acc_sum;
      smp_sync <= 1'b0;
    end
  end

  sync_align_a: assert property (@(posedge clk) disable iff (!rst_b)
    cyc_sync |-> smp_sync && (smp_idx == '0))
    else $error("cycle sync without first sample");
  idx_bound_a: assert property (@(posedge clk) disable iff (!rst_b)
    smp_sync |-> (smp_idx < eff_factor))
    else $error("sample index beyond oversampling factor");
endmodule

//--- oos_sequencer.sv
// Purpose: two-channel oversampled digital output sequencer with cycle and watchdog fault policies
// Assumes: register port is the device's acyclic byte/word access, 12-bit byte address
// Notes: a block carries both channels' samples plus the controller's sequence value and check flag
`timescale 1ns/10ps
module oos_sequencer
  import oos_pkg::*;
#(
  parameter int CYCLE_CLKS = CYCLE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS,
  parameter int WDOG_CLKS = WDOG_TIME_MS * NS_PER_MS / CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // process data blocks from the fieldbus side
  input wire logic blk_valid,
  output logic blk_ready,
  input wire logic [MAX_FACTOR-1:0] blk_ch1,
  input wire logic [MAX_FACTOR-1:0] blk_ch2,
  input wire logic [SEQ_W-1:0] cycle_sequence_value,
  input wire logic sequence_check_enable,
  // configuration
  input wire logic [IDX_W-1:0] os_factor,
  input wire logic ts_enable,
  // acyclic register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  // output stages
  output logic [CH_N-1:0] out_level,
  output logic [CH_N-1:0] out_enable_b,
  // status
  output logic [TIME_W-1:0] next_output_timestamp,
  output logic ts_valid,
  output logic cycle_sync,
  output logic sample_sync,
  output logic [1:0] fault_mode,
  output logic wd_expired
);
  localparam logic [TIME_W-1:0] WDOG_LAST = TIME_W'(WDOG_CLKS - 1);
  localparam logic [TIME_W-1:0] CYCLE_NS = TIME_W'(CYCLE_CLKS * CLK_PERIOD_NS);
  localparam logic [TIME_W-1:0] CLK_STEP_NS = TIME_W'(CLK_PERIOD_NS);
  localparam logic [SEQ_W-1:0] SEQ_STEP = 8'h01;
  localparam logic [1:0] DRIVE_LOW = 2'b00;

  // true when this access touches byte address tgt, lane 0 at addr, lane 1 at addr+1
  function automatic logic byte_hit(input logic [ADDR_W-1:0] a, input logic [1:0] be,
                                    input logic [ADDR_W-1:0] tgt);
    return (a == tgt && be[0]) || (a + ADDR_NEXT_LANE == tgt && be[1]);
  endfunction

  function automatic logic [BYTE_W-1:0] byte_lane(input logic [ADDR_W-1:0] a,
                                                  input logic [DATA_W-1:0] d,
                                                  input logic [ADDR_W-1:0] tgt);
    return (a == tgt) ? d[BYTE_W-1:0] : d[DATA_W-1:BYTE_W];
  endfunction

  function automatic logic [BYTE_W-1:0] reg_byte(input logic [ADDR_W-1:0] a,
                                                 input logic [BYTE_W-1:0] cnt,
                                                 input logic [BYTE_W-1:0] p1,
                                                 input logic [BYTE_W-1:0] p2);
    case (a)
      ADDR_SEQ_ERR: return cnt;
      ADDR_POL_CH1: return p1;
      ADDR_POL_CH2: return p2;
      default: return 8'h00;
    endcase
  endfunction

  // {output enable low-active, level} for a fault action code
  function automatic logic [1:0] oos_drive(input logic [ACT_W-1:0] code, input logic blk,
                                           input logic hold, input logic tgl);
    case (oos_action_t'(code))
      ACT_ZERO: return 2'b00;
      ACT_ONE: return 2'b01;
      ACT_HOLD: return {1'b0, hold};
      ACT_KEEP_BUFFER: return {1'b0, blk};
      ACT_TOGGLE_OUTPUT: return {1'b0, tgl};
      ACT_FLOAT: return 2'b10;
      default: return DRIVE_LOW;
    endcase
  endfunction

  oos_stream_if #(.W(BLK_W)) in_s ();
  oos_stream_if #(.W(BLK_W)) out_s ();

  logic cyc_sync;
  logic smp_sync;
  logic [IDX_W-1:0] smp_idx;
  logic [IDX_W-1:0] eff_factor;
  logic take;
  logic [SEQ_W-1:0] new_seq;
  logic new_chk;
  logic [SEQ_W-1:0] prev_seq;
  logic have_prev;
  logic chk_en;
  logic seq_jump;
  logic cc_err;
  logic next_cc_err;
  logic [BYTE_W-1:0] err_cnt;
  logic wr_cnt;
  logic [BYTE_W-1:0] pol [CH_N];
  logic [TIME_W-1:0] wd_cnt;
  logic wd_exp;
  logic [TIME_W-1:0] local_time;
  logic [SEQ_LSB-1:0] cur_blk;
  logic [SEQ_LSB-1:0] src_blk;
  oos_mode_t mode_now;
  oos_mode_t mode;

  assign in_s.valid = blk_valid;
  assign in_s.data = {sequence_check_enable, cycle_sequence_value, blk_ch2, blk_ch1};
  assign blk_ready = in_s.ready;

  oos_fifo #(.W(BLK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .wr(in_s),
    .rd(out_s)
  );

  oos_sync_gen #(.CYCLE_CLKS(CYCLE_CLKS)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .factor(os_factor),
    .cyc_sync(cyc_sync),
    .smp_sync(smp_sync),
    .smp_idx(smp_idx),
    .eff_factor(eff_factor)
  );

  assign cycle_sync = cyc_sync;
  assign sample_sync = smp_sync;

  // blocks are only taken over at the cycle sync, so the FIFO back-pressures between syncs
  assign take = cyc_sync & out_s.valid;
  assign out_s.ready = take;
  assign new_seq = out_s.data[SEQ_LSB +: SEQ_W];
  assign new_chk = out_s.data[CHK_BIT];
  // the taken block is visible at once, so bit zero leaves at the cycle sync itself
  assign src_blk = take ? out_s.data[SEQ_LSB-1:0] : cur_blk;

  // a jump compares only against the previous value, so later single steps stay clean
  assign seq_jump = take && new_chk && have_prev && (new_seq != prev_seq + SEQ_STEP);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      prev_seq <= '0;
      have_prev <= 1'b0;
      chk_en <= 1'b0;
    end else if (take) begin
      prev_seq <= new_seq;
      have_prev <= new_chk;
      chk_en <= new_chk;
    end
  end

  // missing data counts as an error only while checking is on
  always_comb begin
    next_cc_err = cc_err;
    if (cyc_sync) begin
      next_cc_err = take ? seq_jump : chk_en;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cc_err <= 1'b0;
    end else begin
      cc_err <= next_cc_err;
    end
  end

  assign wr_cnt = reg_wr && byte_hit(reg_addr, reg_be, ADDR_SEQ_ERR);

  // an increment in the same cycle as a software write is kept on top of the written value
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_cnt <= SEQ_ERR_RESET;
    end else if (seq_jump) begin
      err_cnt <= (wr_cnt ? byte_lane(reg_addr, reg_wdata, ADDR_SEQ_ERR) : err_cnt) + SEQ_STEP;
    end else if (wr_cnt) begin
      err_cnt <= byte_lane(reg_addr, reg_wdata, ADDR_SEQ_ERR);
    end
  end

  // policy bytes change only by write or reset; a word write at the first byte sets both
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pol[0] <= POL_RESET;
      pol[1] <= POL_RESET;
    end else if (reg_wr) begin
      if (byte_hit(reg_addr, reg_be, ADDR_POL_CH1)) begin
        pol[0] <= byte_lane(reg_addr, reg_wdata, ADDR_POL_CH1);
      end
      if (byte_hit(reg_addr, reg_be, ADDR_POL_CH2)) begin
        pol[1] <= byte_lane(reg_addr, reg_wdata, ADDR_POL_CH2);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= {reg_byte(reg_addr + ADDR_NEXT_LANE, err_cnt, pol[0], pol[1]),
                    reg_byte(reg_addr, err_cnt, pol[0], pol[1])};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wd_cnt <= '0;
      wd_exp <= 1'b0;
    end else if (take) begin
      wd_cnt <= '0;
      wd_exp <= 1'b0;
    end else if (wd_cnt == WDOG_LAST) begin
      wd_exp <= 1'b1;
    end else begin
      wd_cnt <= wd_cnt + 1'b1;
    end
  end

  assign wd_expired = wd_exp;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur_blk <= '0;
    end else if (take) begin
      cur_blk <= out_s.data[SEQ_LSB-1:0];
    end
  end

  always_comb begin
    if (wd_exp && !take) begin
      mode_now = MODE_WATCHDOG;
    end else if (next_cc_err) begin
      mode_now = MODE_CYCLE_ERR;
    end else begin
      mode_now = MODE_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode <= MODE_NORMAL;
    end else begin
      mode <= mode_now;
    end
  end

  assign fault_mode = mode;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      local_time <= '0;
    end else begin
      local_time <= local_time + CLK_STEP_NS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      next_output_timestamp <= '0;
      ts_valid <= 1'b0;
    end else if (cyc_sync) begin
      next_output_timestamp <= ts_enable ? local_time + CYCLE_NS : '0;
      ts_valid <= ts_enable;
    end
  end

  for (genvar c = 0; c < CH_N; c++) begin : g_ch
    logic blk_bit;
    logic hold_bit;
    logic hold_now;
    logic tgl_bit;
    logic lvl_q;
    logic oe_q;
    logic [1:0] act;

    assign blk_bit = src_blk[c * MAX_FACTOR + int'(smp_idx)];
    // last bit of the previous cycle is the level still on the pin at the cycle sync
    assign hold_now = cyc_sync ? lvl_q : hold_bit;

    always_comb begin
      case (mode_now)
        MODE_WATCHDOG: begin
          act = pol[c][POL_EN_BIT] ?
                oos_drive(pol[c][POL_WD_LSB +: ACT_W], blk_bit, hold_now, tgl_bit) : DRIVE_LOW;
        end
        MODE_CYCLE_ERR: begin
          act = pol[c][POL_EN_BIT] ?
                oos_drive(pol[c][POL_CC_LSB +: ACT_W], blk_bit, hold_now, tgl_bit) : DRIVE_LOW;
        end
        MODE_NORMAL: begin
          act = {1'b0, blk_bit};
        end
        default: begin
          act = DRIVE_LOW;
        end
      endcase
    end

    always_ff @(posedge clk) begin
      if (!rst_b) begin
        lvl_q <= 1'b0;
        oe_q <= 1'b0;
        tgl_bit <= 1'b0;
        hold_bit <= 1'b0;
      end else if (smp_sync) begin
        lvl_q <= act[0];
        oe_q <= act[1];
        tgl_bit <= (mode_now == MODE_NORMAL) ? 1'b0 : ~tgl_bit;
        if (cyc_sync) begin
          hold_bit <= lvl_q;
        end
      end
    end

    assign out_level[c] = lvl_q;
    assign out_enable_b[c] = oe_q;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  take_at_sync_a: assert property (!cyc_sync |=> $stable(cur_blk) && $stable(prev_seq))
    else $error("block taken outside cycle sync");
  err_count_step_a: assert property (seq_jump && !wr_cnt |=> err_cnt == $past(err_cnt) + SEQ_STEP)
    else $error("sequence error not counted once");
  seq_wrap_a: assert property (take && have_prev && prev_seq == 8'hff && new_seq == 8'h00 && !wr_cnt
    |=> err_cnt == $past(err_cnt))
    else $error("sequence wrap counted as error");
  count_clear_a: assert property (wr_cnt && !seq_jump |=> err_cnt == $past(reg_wdata[BYTE_W-1:0])
    || err_cnt == $past(reg_wdata[DATA_W-1:BYTE_W]))
    else $error("error count write lost");
  normal_bit_a: assert property (smp_sync && mode_now == MODE_NORMAL
    |=> out_level[0] == $past(g_ch[0].blk_bit) && !out_enable_b[0])
    else $error("sample bit not driven");
  wd_default_a: assert property (smp_sync && mode_now == MODE_WATCHDOG && !pol[0][POL_EN_BIT]
    |=> !out_level[0] && !out_enable_b[0])
    else $error("expired watchdog without policy not driving zero");
  float_out_a: assert property (smp_sync && pol[1][POL_EN_BIT]
    && ((mode_now == MODE_CYCLE_ERR && pol[1][POL_CC_LSB +: ACT_W] == ACT_FLOAT)
    || (mode_now == MODE_WATCHDOG && pol[1][POL_WD_LSB +: ACT_W] == ACT_FLOAT)) |=> out_enable_b[1])
    else $error("float action still drives the pin");
  wd_restart_a: assert property (take |=> wd_cnt == '0 && !wd_exp ##1 !wd_exp)
    else $error("watchdog not restarted by a good cycle");
  stamp_next_a: assert property (cyc_sync && ts_enable
    |=> next_output_timestamp == $past(local_time) + CYCLE_NS && ts_valid)
    else $error("next output timestamp wrong");
endmodule

//--- oos_master_model.sv
// Purpose: fieldbus master stand-in that hands process data blocks to the sequencer
// Assumes: one block per send call, valid held until ready is sampled high
// Notes: released channel and sequence lines show the inverse of the last block, the check flag keeps its value
`timescale 1ns/10ps
module oos_master_model
  import oos_pkg::*;
(
  // clock
  input wire logic clk,
  // block stream
  input wire logic blk_ready,
  output logic blk_valid,
  output logic [MAX_FACTOR-1:0] blk_ch1,
  output logic [MAX_FACTOR-1:0] blk_ch2,
  output logic [SEQ_W-1:0] cycle_sequence_value,
  output logic sequence_check_enable
);
  initial begin
    blk_valid = 1'b0;
    blk_ch1 = '0;
    blk_ch2 = '1;
    cycle_sequence_value = 8'h00;
    sequence_check_enable = 1'b0;
  end

  task automatic send(input logic [MAX_FACTOR-1:0] c1, input logic [MAX_FACTOR-1:0] c2,
                      input logic [SEQ_W-1:0] s, input logic k);
    @(negedge clk);
    blk_valid = 1'b1;
    blk_ch1 = c1;
    blk_ch2 = c2;
    cycle_sequence_value = s;
    sequence_check_enable = k;
    @(posedge clk);
    while (blk_ready !== 1'b1) @(posedge clk);
    blk_valid <= 1'b0;
    blk_ch1 <= ~c1;
    blk_ch2 <= ~c2;
    cycle_sequence_value <= ~s;
  endtask
endmodule

//--- oos_sequencer_tb.sv
// Purpose: self-checking bench for the oversampled output sequencer
// Assumes: short cycle of 200 clocks and watchdog of 1000 clocks
// Notes: inputs change at the falling edge, except the master model's block release at the rising edge
`timescale 1ns/10ps
module oos_sequencer_tb;
  import oos_pkg::*;
  localparam int CYC = 200;
  logic clk, rst_b, blk_valid, blk_ready, sequence_check_enable, ts_enable, reg_wr, reg_rd;
  logic ts_valid, cycle_sync, sample_sync, wd_expired;
  logic [MAX_FACTOR-1:0] blk_ch1, blk_ch2;
  logic [SEQ_W-1:0] cycle_sequence_value;
  logic [IDX_W-1:0] os_factor;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [1:0] reg_be, fault_mode;
  logic [CH_N-1:0] out_level, out_enable_b;
  logic [TIME_W-1:0] next_output_timestamp, t0;
  logic [7:0] sv [8] = '{8'h01, 8'h02, 8'h06, 8'h07, 8'h07, 8'h08, 8'hff, 8'h00};
  logic [15:0] pol [2] = '{16'h1150, 16'h5150};
  logic [3:0] pexp [2] = '{4'h2, 4'h8};
  int n_errors = 0;
  int checked = 0;

  oos_master_model PM (.clk, .blk_ready, .blk_valid, .blk_ch1, .blk_ch2, .cycle_sequence_value,
    .sequence_check_enable);
  oos_sequencer #(.CYCLE_CLKS(CYC), .WDOG_CLKS(1000)) DUT (.clk, .rst_b, .blk_valid, .blk_ready,
    .blk_ch1, .blk_ch2, .cycle_sequence_value, .sequence_check_enable, .os_factor, .ts_enable,
    .reg_addr, .reg_wdata, .reg_be, .reg_wr, .reg_rd, .reg_rdata, .out_level, .out_enable_b,
    .next_output_timestamp, .ts_valid, .cycle_sync, .sample_sync, .fault_mode, .wd_expired);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [1:0] be);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string m);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk_val(reg_rdata, exp, m);
  endtask

  // wait for a sync pulse at a falling edge, bounded by two cycles
  task automatic wsync(input logic cyc);
    for (int i = 0; i < 2 * CYC; i++) begin
      @(negedge clk);
      if ((cyc ? cycle_sync : sample_sync) === 1'b1) break;
    end
  endtask

  task automatic seq_chk(input int n, input logic [7:0] c1, input logic [7:0] c2);
    wsync(1'b1);
    for (int k = 0; k < n; k++) begin
      if (k > 0) wsync(1'b0);
      chk_val({cycle_sync, sample_sync}, {k == 0, 1'b1}, "sample sync position");
      @(negedge clk);
      chk_val(out_level, {c2[k], c1[k]}, "sample bit");
    end
    wsync(1'b0);
    chk_val(cycle_sync, 1'b1, "samples per cycle");
  endtask

  initial begin
    rst_b = 1'b0;
    ts_enable = 1'b1;
    os_factor = 10'h004;
    reg_addr = '0;
    reg_wdata = '0;
    reg_be = 2'b00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    rd(ADDR_SEQ_ERR, 16'h0000, "count reset");
    chk_val(blk_ready, 1'b1, "block ready after reset");
    rd(ADDR_POL_CH1, 16'h0000, "policy reset");
    wr(ADDR_POL_CH1, 16'h2309, 2'b11);
    rd(ADDR_POL_CH1, 16'h2309, "policy word");
    rd(12'h400, 16'h0000, "unmapped read");
    $display("test registers done");
    PM.send(MAX_FACTOR'(4'hd), MAX_FACTOR'(4'h2), 8'h00, 1'b0);
    wsync(1'b1);
    seq_chk(4, 8'h0d, 8'h02);
    PM.send(MAX_FACTOR'(4'h5), MAX_FACTOR'(4'ha), 8'h00, 1'b0);
    @(negedge clk);
    os_factor = 10'h003;
    wsync(1'b1);
    seq_chk(1, 8'h05, 8'h0a);
    $display("test sampling done");
    repeat (5) @(negedge clk);
    t0 = next_output_timestamp;
    chk_val(ts_valid, 1'b1, "timestamp mapped");
    wsync(1'b1);
    repeat (5) @(negedge clk);
    chk_val(next_output_timestamp - t0, CYC * 10, "timestamp step");
    ts_enable = 1'b0;
    wsync(1'b1);
    wsync(1'b1);
    repeat (5) @(negedge clk);
    chk_val(next_output_timestamp + ts_valid, 0, "timestamp removed");
    $display("test timestamp done");
    os_factor = 10'h004;
    for (int i = 0; i < 8; i++) PM.send('0, '0, sv[i], 1'b1);
    repeat (10) wsync(1'b1);
    wsync(1'b0);
    @(negedge clk);
    chk_val({fault_mode, out_level}, 4'h7, "cycle error action");
    wsync(1'b0);
    @(negedge clk);
    chk_val(out_level, 2'h2, "toggle action");
    rd(ADDR_SEQ_ERR, 16'h0003, "sequence errors");
    wr(ADDR_SEQ_ERR, 16'h0000, 2'b01);
    rd(ADDR_SEQ_ERR, 16'h0000, "count cleared");
    $display("test sequence done");
    repeat (6) wsync(1'b1);
    chk_val({wd_expired, fault_mode}, 3'b110, "watchdog expiry");
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_POL_CH1, pol[i], 2'b11);
      wsync(1'b1);
      wsync(1'b0);
      @(negedge clk);
      chk_val({out_enable_b, out_level}, pexp[i], "watchdog action");
    end
    $display("test watchdog done");
    stop_test();
  end

  initial begin
    #400000;
    n_errors++;
    $display("[FAIL] %0t run did not finish in time", $time);
    stop_test();
  end
endmodule
